// ==== core/acs_i2c_slave.sv ====
// two-wire register slave for the four-channel amplifier control block
`timescale 1ns/1ps
// What this block does
// - works at bus rates up to 400 kbps
// - slave only, never drives the clock
// - bytes are eight bits, msb first
// - receiver acknowledges each byte in ninth clock
// - sda fall/rise with scl high: start/stop
// - sda changes only while scl is low
// - ack holds sda low whole high phase
// - address 11011 plus two select-pin bits
// - direction 0 writes, 1 reads
// - no byte count limit per transfer
// - write: address, subaddress, data, each acked
// - each byte written to a control offset stored, pointer increments
// - read: subaddress write, restart, read address
// - master nacks last byte; pointer increments
// - 0x00-0x07 and 0x13 are read-only status
// - 0x08-0x0D and 0x10 are read/write control
// - select pin sensed as four levels
module acs_i2c_slave (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] addr_sel,
	input wire acs_pkg::acs_status_t status_in,
	output acs_pkg::acs_ctrl_t ctrl_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	acs_pkg::acs_state_t state_r, state_nxt;
	logic scl_q_r, scl_q_nxt;
	logic sda_q_r, sda_q_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic mack_r, mack_nxt;
	logic sda_oe_r, sda_oe_nxt;
	logic sda_out_r, sda_out_nxt;
	acs_pkg::acs_ctrl_t ctrl_r, ctrl_nxt;

	logic scl_rise, scl_fall, start_det, stop_det;
	logic addr_match, wr_en;
	logic [7:0] rd_byte;

	assign sda_out = sda_out_r;
	assign sda_oe = sda_oe_r;
	assign ctrl_out = ctrl_r;

	// ----------------------------------------------------------------
	// bus conditions
	// ----------------------------------------------------------------
	// one sample stage is enough: inputs already arrive synchronous,
	// and 400 kbps leaves about sixty system clocks per bit
	assign scl_rise = scl_in & ~scl_q_r;
	assign scl_fall = ~scl_in & scl_q_r;
	assign start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
	assign stop_det = scl_in & scl_q_r & ~sda_q_r & sda_in;

	// the select pin level is resolved to two bits by the analog sensor
	assign addr_match = (shift_r[7:1] == {acs_pkg::ADDR_FIXED, addr_sel});

	assign wr_en = (state_r == acs_pkg::ST_WDATA) & scl_fall
		& (cnt_r == acs_pkg::BYTE_BITS);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		case (ptr_r)
			acs_pkg::REG_LATCHED_FAULT_GLOBAL: rd_byte = status_in.latched_fault_global;
			acs_pkg::REG_LATCHED_FAULT_PER_CHANNEL: begin
				rd_byte = status_in.latched_fault_per_channel;
			end
			acs_pkg::REG_LATCHED_LOAD_DIAG_A: rd_byte = status_in.latched_load_diag_a;
			acs_pkg::REG_LATCHED_LOAD_DIAG_B: rd_byte = status_in.latched_load_diag_b;
			acs_pkg::REG_TEMP_VOLTAGE_STATUS: rd_byte = status_in.temp_voltage_status;
			acs_pkg::REG_OUTPUT_STATE_STATUS: rd_byte = status_in.output_state_status;
			acs_pkg::REG_MUTE_PLAY_STATUS: rd_byte = status_in.mute_play_status;
			acs_pkg::REG_LOAD_DIAG_STATUS: rd_byte = status_in.load_diag_status;
			acs_pkg::REG_THERMAL_SHUTDOWN_FOLDBACK_STATUS: begin
				rd_byte = status_in.thermal_shutdown_foldback_status;
			end
			acs_pkg::REG_CHANNEL_GAIN_CTRL: rd_byte = ctrl_r.channel_gain_ctrl;
			acs_pkg::REG_OVERCURRENT_CTRL: rd_byte = ctrl_r.overcurrent_ctrl;
			acs_pkg::REG_SWITCH_FREQ_CLIP_CTRL: rd_byte = ctrl_r.switch_freq_clip_ctrl;
			acs_pkg::REG_DIAG_MASTER_CTRL: rd_byte = ctrl_r.diag_master_ctrl;
			acs_pkg::REG_OUTPUT_STATE_CTRL_A: rd_byte = ctrl_r.output_state_ctrl_a;
			acs_pkg::REG_OUTPUT_STATE_CTRL_B: rd_byte = ctrl_r.output_state_ctrl_b;
			acs_pkg::REG_DC_DETECT_THRESHOLD_CTRL: begin
				rd_byte = ctrl_r.dc_detect_threshold_ctrl;
			end
			default: rd_byte = acs_pkg::BYTE_ZERO;
		endcase
	end

	// ----------------------------------------------------------------
	// control register writes
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_en) begin
			// read-only and unused offsets fall through untouched
			case (ptr_r)
				acs_pkg::REG_CHANNEL_GAIN_CTRL: ctrl_nxt.channel_gain_ctrl = shift_r;
				acs_pkg::REG_OVERCURRENT_CTRL: ctrl_nxt.overcurrent_ctrl = shift_r;
				acs_pkg::REG_SWITCH_FREQ_CLIP_CTRL: begin
					ctrl_nxt.switch_freq_clip_ctrl = shift_r;
				end
				acs_pkg::REG_DIAG_MASTER_CTRL: ctrl_nxt.diag_master_ctrl = shift_r;
				acs_pkg::REG_OUTPUT_STATE_CTRL_A: ctrl_nxt.output_state_ctrl_a = shift_r;
				acs_pkg::REG_OUTPUT_STATE_CTRL_B: ctrl_nxt.output_state_ctrl_b = shift_r;
				acs_pkg::REG_DC_DETECT_THRESHOLD_CTRL: begin
					ctrl_nxt.dc_detect_threshold_ctrl = shift_r;
				end
				default: ctrl_nxt = ctrl_r;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// protocol engine
	// ----------------------------------------------------------------
	// sda only ever moves on a detected scl fall, so the line is stable
	// through every high phase; the clock pin is never driven at all
	always_comb begin
		state_nxt = state_r;
		scl_q_nxt = scl_in;
		sda_q_nxt = sda_in;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		ptr_nxt = ptr_r;
		mack_nxt = mack_r;
		sda_oe_nxt = sda_oe_r;
		sda_out_nxt = 1'b0;
		if (start_det) begin
			// a repeated start keeps the pointer for the read phase
			state_nxt = acs_pkg::ST_ADDR;
			cnt_nxt = acs_pkg::CNT_ZERO;
			sda_oe_nxt = 1'b0;
		end else if (stop_det) begin
			state_nxt = acs_pkg::ST_IDLE;
			sda_oe_nxt = 1'b0;
		end else begin
			case (state_r)
				acs_pkg::ST_ADDR, acs_pkg::ST_SUB, acs_pkg::ST_WDATA: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_in};
						cnt_nxt = cnt_r + acs_pkg::CNT_ONE;
					end else if (scl_fall && cnt_r == acs_pkg::BYTE_BITS) begin
						cnt_nxt = acs_pkg::CNT_ZERO;
						sda_oe_nxt = 1'b1;
						if (state_r == acs_pkg::ST_ADDR) begin
							if (addr_match) begin
								state_nxt = acs_pkg::ST_ADDR_ACK;
							end else begin
								state_nxt = acs_pkg::ST_IGNORE;
								sda_oe_nxt = 1'b0;
							end
						end else if (state_r == acs_pkg::ST_SUB) begin
							ptr_nxt = shift_r;
							state_nxt = acs_pkg::ST_SUB_ACK;
						end else begin
							ptr_nxt = ptr_r + acs_pkg::PTR_STEP;
							state_nxt = acs_pkg::ST_WACK;
						end
					end
				end
				acs_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (shift_r[0]) begin
							tx_nxt = rd_byte;
							sda_oe_nxt = ~rd_byte[7];
							cnt_nxt = acs_pkg::CNT_ONE;
							state_nxt = acs_pkg::ST_RDATA;
						end else begin
							sda_oe_nxt = 1'b0;
							state_nxt = acs_pkg::ST_SUB;
						end
					end
				end
				acs_pkg::ST_SUB_ACK, acs_pkg::ST_WACK: begin
					if (scl_fall) begin
						sda_oe_nxt = 1'b0;
						state_nxt = acs_pkg::ST_WDATA;
					end
				end
				acs_pkg::ST_RDATA: begin
					if (scl_fall) begin
						if (cnt_r == acs_pkg::BYTE_BITS) begin
							sda_oe_nxt = 1'b0;
							ptr_nxt = ptr_r + acs_pkg::PTR_STEP;
							state_nxt = acs_pkg::ST_RACK;
						end else begin
							tx_nxt = {tx_r[6:0], 1'b0};
							sda_oe_nxt = ~tx_r[6];
							cnt_nxt = cnt_r + acs_pkg::CNT_ONE;
						end
					end
				end
				acs_pkg::ST_RACK: begin
					if (scl_rise) begin
						mack_nxt = ~sda_in;
					end else if (scl_fall) begin
						if (mack_r) begin
							tx_nxt = rd_byte;
							sda_oe_nxt = ~rd_byte[7];
							cnt_nxt = acs_pkg::CNT_ONE;
							state_nxt = acs_pkg::ST_RDATA;
						end else begin
							state_nxt = acs_pkg::ST_IGNORE;
						end
					end
				end
				acs_pkg::ST_IDLE, acs_pkg::ST_IGNORE: begin
					sda_oe_nxt = 1'b0;
				end
				default: begin
					state_nxt = acs_pkg::ST_IDLE;
					sda_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= acs_pkg::ST_IDLE;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			cnt_r <= acs_pkg::CNT_ZERO;
			shift_r <= acs_pkg::BYTE_ZERO;
			tx_r <= acs_pkg::BYTE_ZERO;
			ptr_r <= acs_pkg::BYTE_ZERO;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
			sda_out_r <= 1'b0;
			ctrl_r <= {7{acs_pkg::CTRL_RST}};
		end else begin
			state_r <= state_nxt;
			scl_q_r <= scl_q_nxt;
			sda_q_r <= sda_q_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			mack_r <= mack_nxt;
			sda_oe_r <= sda_oe_nxt;
			sda_out_r <= sda_out_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ack_whole_high: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(state_r == acs_pkg::ST_ADDR_ACK || state_r == acs_pkg::ST_SUB_ACK
			|| state_r == acs_pkg::ST_WACK) && scl_q_r |-> sda_oe_r)
		else $error("ack released during clock high");

	a_sda_stable_high: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		scl_q_r && $past(scl_q_r) |-> $stable(sda_oe_r))
		else $error("sda drive changed while scl high");

	a_nomatch_silent: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		state_r == acs_pkg::ST_ADDR && scl_fall && cnt_r == acs_pkg::BYTE_BITS
			&& !addr_match && !start_det && !stop_det
		|=> state_r == acs_pkg::ST_IGNORE && !sda_oe_r)
		else $error("foreign address acknowledged");

	a_match_acks: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		state_r == acs_pkg::ST_ADDR && scl_fall && cnt_r == acs_pkg::BYTE_BITS
			&& addr_match && !start_det && !stop_det
		|=> state_r == acs_pkg::ST_ADDR_ACK ##1 sda_oe_r)
		else $error("own address not acknowledged");

	a_write_ptr_step: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		wr_en && !start_det && !stop_det
		|=> ptr_r == $past(ptr_r) + acs_pkg::PTR_STEP && sda_oe_r)
		else $error("pointer not advanced after write");

	a_ro_unchanged: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!wr_en || ptr_r < acs_pkg::REG_CHANNEL_GAIN_CTRL
		|=> ctrl_r == $past(ctrl_r))
		else $error("control changed without legal write");

	a_write_lands: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		wr_en && ptr_r == acs_pkg::REG_CHANNEL_GAIN_CTRL
		|=> ctrl_r.channel_gain_ctrl == $past(shift_r))
		else $error("gain byte not stored");

	a_start_restarts: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		start_det |=> state_r == acs_pkg::ST_ADDR && !sda_oe_r
			&& cnt_r == acs_pkg::CNT_ZERO)
		else $error("start not honoured");

	a_stop_idles: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		stop_det |=> state_r == acs_pkg::ST_IDLE && !sda_oe_r)
		else $error("stop not honoured");

	a_read_msb_out: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		state_r == acs_pkg::ST_RDATA && scl_rise |-> sda_oe_r == ~tx_r[7])
		else $error("read bit does not match msb");

	a_read_ptr_step: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		state_r == acs_pkg::ST_RDATA && scl_fall && cnt_r == acs_pkg::BYTE_BITS
			&& !start_det && !stop_det
		|=> state_r == acs_pkg::ST_RACK && !sda_oe_r
			&& ptr_r == $past(ptr_r) + acs_pkg::PTR_STEP)
		else $error("read byte end mishandled");

	a_never_drive_high: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!sda_out_r)
		else $error("sda driven high");

	a_sub_sets_ptr: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		state_r == acs_pkg::ST_SUB && scl_fall && cnt_r == acs_pkg::BYTE_BITS
		|=> state_r == acs_pkg::ST_SUB_ACK && sda_oe_r && ptr_r == $past(shift_r))
		else $error("subaddress not taken as pointer");

	a_ack_then_free: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(state_r == acs_pkg::ST_SUB_ACK || state_r == acs_pkg::ST_WACK) && scl_fall
		|=> state_r == acs_pkg::ST_WDATA && !sda_oe_r)
		else $error("ack not released after ninth clock");

	a_read_first_bit: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		state_r == acs_pkg::ST_ADDR_ACK && scl_fall && shift_r[0]
		|=> state_r == acs_pkg::ST_RDATA && cnt_r == acs_pkg::CNT_ONE
			&& tx_r == $past(rd_byte) && sda_oe_r == ~tx_r[7])
		else $error("first read bit not driven");

	a_nack_ends_read: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		state_r == acs_pkg::ST_RACK && scl_fall && !mack_r
		|=> state_r == acs_pkg::ST_IGNORE && !sda_oe_r)
		else $error("read went on after nack");

	a_ro_write_none: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		wr_en && (ptr_r < acs_pkg::REG_CHANNEL_GAIN_CTRL
			|| (ptr_r > acs_pkg::REG_OUTPUT_STATE_CTRL_B
			&& ptr_r != acs_pkg::REG_DC_DETECT_THRESHOLD_CTRL))
		|=> ctrl_r == $past(ctrl_r))
		else $error("write to read-only place took effect");

	a_oe_after_fall: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		$changed(sda_oe_r) && !$past(start_det) && !$past(stop_det) |-> $past(scl_fall))
		else $error("sda drive moved outside clock low");

endmodule

// ==== pkg/acs_pkg.sv ====
// shared constants, register map and carrier types of the amplifier control slave
package acs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int BUS_MAX_BPS = 400_000;
	localparam int BIT_CYCLES = CLK_HZ / BUS_MAX_BPS;

	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_FIXED = 5'h1B;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [7:0] PTR_STEP = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_LATCHED_FAULT_GLOBAL = 8'h00;
	localparam logic [7:0] REG_LATCHED_FAULT_PER_CHANNEL = 8'h01;
	localparam logic [7:0] REG_LATCHED_LOAD_DIAG_A = 8'h02;
	localparam logic [7:0] REG_LATCHED_LOAD_DIAG_B = 8'h03;
	localparam logic [7:0] REG_TEMP_VOLTAGE_STATUS = 8'h04;
	localparam logic [7:0] REG_OUTPUT_STATE_STATUS = 8'h05;
	localparam logic [7:0] REG_MUTE_PLAY_STATUS = 8'h06;
	localparam logic [7:0] REG_LOAD_DIAG_STATUS = 8'h07;
	localparam logic [7:0] REG_CHANNEL_GAIN_CTRL = 8'h08;
	localparam logic [7:0] REG_OVERCURRENT_CTRL = 8'h09;
	localparam logic [7:0] REG_SWITCH_FREQ_CLIP_CTRL = 8'h0A;
	localparam logic [7:0] REG_DIAG_MASTER_CTRL = 8'h0B;
	localparam logic [7:0] REG_OUTPUT_STATE_CTRL_A = 8'h0C;
	localparam logic [7:0] REG_OUTPUT_STATE_CTRL_B = 8'h0D;
	localparam logic [7:0] REG_DC_DETECT_THRESHOLD_CTRL = 8'h10;
	localparam logic [7:0] REG_THERMAL_SHUTDOWN_FOLDBACK_STATUS = 8'h13;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] latched_fault_global;
		logic [7:0] latched_fault_per_channel;
		logic [7:0] latched_load_diag_a;
		logic [7:0] latched_load_diag_b;
		logic [7:0] temp_voltage_status;
		logic [7:0] output_state_status;
		logic [7:0] mute_play_status;
		logic [7:0] load_diag_status;
		logic [7:0] thermal_shutdown_foldback_status;
	} acs_status_t;

	typedef struct packed {
		logic [7:0] channel_gain_ctrl;
		logic [7:0] overcurrent_ctrl;
		logic [7:0] switch_freq_clip_ctrl;
		logic [7:0] diag_master_ctrl;
		logic [7:0] output_state_ctrl_a;
		logic [7:0] output_state_ctrl_b;
		logic [7:0] dc_detect_threshold_ctrl;
	} acs_ctrl_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
		ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_IGNORE
	} acs_state_t;

endpackage

// ==== dv/acs_bus_master.sv ====
// two-wire bus master model standing on the far side of the slave
`timescale 1ns/1ps
module acs_bus_master #(
	parameter int QTR = 16
) (
	input wire logic sys_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	// ------------------------------------------------
	// bus phases, every change lands on a falling sys_clk edge
	// ------------------------------------------------
	// scl stands high between frames; sda is released to its pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic qw();
		repeat (QTR) @(negedge sys_clk);
	endtask
	// also serves as repeated start when scl is low on entry
	task automatic start();
		sda_pull = 1'b0;
		qw();
		scl = 1'b1;
		qw();
		sda_pull = 1'b1;
		qw();
		scl = 1'b0;
		qw();
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		qw();
		scl = 1'b1;
		qw();
		sda_pull = 1'b0;
		qw();
	endtask
	// four quarters of 16 cycles give about 390 kbps
	task automatic bit_io(input logic b, output logic s);
		sda_pull = ~b;
		qw();
		scl = 1'b1;
		qw();
		s = sda;
		qw();
		scl = 1'b0;
		qw();
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// low ack on every byte but the last, which is left high
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, s);
	endtask
endmodule

// ==== dv/acs_i2c_slave_bench.sv ====
// self-checking bench for the amplifier control two-wire slave
`timescale 1ns/1ps
module acs_i2c_slave_bench;
	logic sys_clk;
	logic nrst;
	logic scl;
	logic sda;
	logic m_pull;
	logic sda_out;
	logic sda_oe;
	logic [1:0] addr_sel;
	acs_pkg::acs_status_t status_in;
	acs_pkg::acs_ctrl_t ctrl_out;
	int bad_count;
	int checks;
	logic ack;
	logic [7:0] d;

	// open-drain wire with pull-up: low while either party pulls
	assign sda = ~(m_pull | sda_oe);

	acs_i2c_slave dut_u (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .status_in(status_in),
		.ctrl_out(ctrl_out));
	acs_bus_master m_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(m_pull));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic send_addr(input logic [1:0] sel, input logic rd, input logic exp_ack);
		m_u.wr_byte({acs_pkg::ADDR_FIXED, sel, rd}, ack);
		chk({7'h00, ack}, {7'h00, exp_ack});
	endtask
	task automatic send_data(input logic [7:0] v);
		m_u.wr_byte(v, ack);
		chk({7'h00, ack}, 8'h01);
	endtask
	// status bytes are 0x80+offset, 0x13 gives 0x88; control as written below
	function automatic logic [7:0] exp_rd(input int a);
		if (a < 8) return 8'h80 + 8'(a);
		if (a == 19) return 8'h88;
		if (a < 14) return 8'hA0 + 8'(a - 8);
		if (a == 16) return 8'hA8;
		return 8'h00;
	endfunction

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 7; i++) begin
			chk(ctrl_out[8*i +: 8], 8'h00);
		end
		chk({7'h00, sda_oe}, 8'h00);
		chk({7'h00, sda_out}, 8'h00);
	endtask
	// runs over all control places and the unused gap up to 0x10
	task automatic t_write_seq();
		m_u.start();
		send_addr(2'h0, 1'b0, 1'b1);
		send_data(8'h08);
		for (int i = 0; i < 9; i++) begin
			send_data(8'hA0 + 8'(i));
		end
		m_u.stop();
		for (int i = 0; i < 6; i++) begin
			chk(ctrl_out[55-8*i -: 8], 8'hA0 + 8'(i));
		end
		chk(ctrl_out.dc_detect_threshold_ctrl, 8'hA8);
	endtask
	// write into a read-only place, then read the whole map back
	task automatic t_ro_read();
		m_u.start();
		send_addr(2'h0, 1'b0, 1'b1);
		send_data(8'h00);
		send_data(8'hFF);
		m_u.stop();
		m_u.start();
		send_addr(2'h0, 1'b0, 1'b1);
		send_data(8'h00);
		m_u.start();
		send_addr(2'h0, 1'b1, 1'b1);
		for (int a = 0; a < 20; a++) begin
			m_u.rd_byte(a == 19, d);
			chk(d, exp_rd(a));
		end
		m_u.stop();
	endtask
	// reset in mid run clears the controls and returns the pointer to zero
	task automatic t_mid_reset();
		nrst = 1'b0;
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		t_reset();
		repeat (2) @(negedge sys_clk);
		m_u.start();
		send_addr(2'h0, 1'b1, 1'b1);
		m_u.rd_byte(1'b1, d);
		m_u.stop();
		chk(d, exp_rd(0));
	endtask
	// each select code: a foreign address is ignored, the own one works
	task automatic t_addr_sel();
		for (int s = 0; s < 4; s++) begin
			addr_sel = 2'(s);
			m_u.start();
			send_addr(2'(s + 1), 1'b0, 1'b0);
			send_addr(2'(s), 1'b0, 1'b0);
			m_u.stop();
			m_u.start();
			send_addr(2'(s), 1'b0, 1'b1);
			send_data(8'h10);
			send_data(8'(s));
			m_u.stop();
			chk(ctrl_out.dc_detect_threshold_ctrl, 8'(s));
		end
	endtask

	// ------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------
	initial begin
		bad_count = 0;
		checks = 0;
		nrst = 1'b0;
		addr_sel = 2'h0;
		status_in = 72'h80_81_82_83_84_85_86_87_88;
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		t_reset();
		repeat (2) @(negedge sys_clk);
		t_write_seq();
		t_ro_read();
		t_mid_reset();
		t_addr_sel();
		final_report();
	end
	// about 60 bytes of 576 cycles each fit well inside this span
	initial begin
		repeat (80000) @(posedge sys_clk);
		bad_count++;
		final_report();
	end
endmodule
